// file: rtl/aisp_pkg.sv
// Purpose: shared constants for the analog input sample port
// Assumes: 16-bit register words, 5-bit word address space
// Notes:   offsets, field positions and channel constants live here only

package aisp_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 16;
  localparam int RESULT_W = 12;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_QUEUE = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SETUP = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_STATE = 5'h1A;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 5'h1C;

  // ----------------------------------------------------------------
  // setup entry fields
  // ----------------------------------------------------------------
  localparam int F_SE      = 15;
  localparam int F_AIS     = 14;
  localparam int F_CAL     = 13;
  localparam int F_BIP     = 12;
  localparam int F_SEL_HI  = 11;
  localparam int F_SEL_LO  = 6;
  localparam int F_GAIN_HI = 5;
  localparam int F_GAIN_LO = 3;
  localparam int F_LAST    = 2;
  localparam int F_DISCARD = 1;
  localparam int F_SERIAL  = 0;

  // ----------------------------------------------------------------
  // flag and control bits
  // ----------------------------------------------------------------
  localparam int FL_NOT_EMPTY  = 0;
  localparam int FL_BELOW_HALF = 1;
  localparam int FL_OVERFLOW   = 2;
  localparam int FL_COLLISION  = 3;
  localparam int FL_SETUP_USED = 4;
  localparam int FL_W          = 5;
  localparam int ST_IDLE       = 0;
  localparam int CT_CLR_ERR    = 0;
  localparam int CT_SETUP_CLR  = 1;
  localparam int CT_SETUP_LOAD = 2;
  localparam int CT_RESTART    = 3;

  // ----------------------------------------------------------------
  // differential channel pairing
  // ----------------------------------------------------------------
  localparam logic [5:0] CH_EXT_FIRST = 6'h10;
  localparam logic [5:0] CH_EXT_NEG   = 6'h28;
  localparam logic [5:0] CH_EXT_SPAN  = 6'h18;
  localparam logic [2:0] CH_NEG_BANK  = 3'h1;
  localparam logic [2:0] CH_POS_BANK  = 3'h0;

  typedef enum logic [1:0]
  {
    CONV_IDLE = 2'b00,
    CONV_ARM  = 2'b01,
    CONV_RUN  = 2'b11
  } conv_state_e;

  typedef enum logic [1:0]
  {
    ROUTE_DIFFERENTIAL_INPUT  = 2'h0,
    ROUTE_REF   = 2'h1,
    ROUTE_UNREF = 2'h2,
    ROUTE_CAL   = 2'h3
  } route_e;

endpackage

// file: rtl/queue_if.sv
// Purpose: link between the port logic and its sample queue
// Assumes: one clock shared by both ends
// Notes:   owner pushes and pops, store keeps the words

`timescale 1ns/1ps
`default_nettype none

interface queue_if
#(
  parameter int W  = 16,
  parameter int CW = 10
);
  logic          push;
  logic [W-1:0]  push_data;
  logic          pop;
  logic [W-1:0]  head;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;

  modport owner
  (
    output push, push_data, pop,
    input  head, count, full, empty
  );

  modport store
  (
    input  push, push_data, pop,
    output head, count, full, empty
  );
endinterface

`default_nettype wire

// file: rtl/sample_queue.sv
// Purpose: first-in first-out store for conversion results
// Assumes: DEPTH is a power of two
// Notes:   push while full is dropped, pop while empty is ignored

`timescale 1ns/1ps
`default_nettype none

module sample_queue
#(
  parameter int W     = 16,
  parameter int DEPTH = 512,
  parameter int CW    = 10
)
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  queue_if.store    q
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          do_push;
  logic          do_pop;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign q.full  = (count_reg == CW'(DEPTH));
  assign q.empty = (count_reg == '0);
  assign q.count = count_reg;
  assign q.head  = mem[rd_ptr_reg];
  assign do_push = q.push & ~q.full;
  assign do_pop  = q.pop & ~q.empty;

  always_ff @(posedge i_clk)
  begin
    if (i_ce && do_push)
    begin
      mem[wr_ptr_reg] <= q.push_data;
    end
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (i_ce)
    begin
      if (do_push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/analog_input_sample_port.sv
// Purpose: host-side logic of an analog input section
// Assumes: converter strobes on pins, 25 MHz i_clk, plain register port
// Notes:   converter busy pin and start pin are resynchronised
//
// The implementer's own choice: the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module analog_input_sample_port
#(
  parameter int QUEUE_DEPTH = 512,
  parameter int SETUP_DEPTH = 512
)
(
  input  wire logic                            i_clk,
  input  wire logic                            i_srst,
  input  wire logic                            i_ce,
  input  wire logic [aisp_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [aisp_pkg::DATA_W-1:0]     i_wdata,
  input  wire logic                            i_wr,
  input  wire logic                            i_rd,
  output logic      [aisp_pkg::DATA_W-1:0]     o_rdata,
  input  wire logic                            i_conv_start_pin,
  input  wire logic                            i_adc_busy_n_pin,
  input  wire logic [aisp_pkg::RESULT_W-1:0]   i_adc_data,
  output logic                                 o_adc_start,
  output logic      [1:0]                      o_route_mode,
  output logic      [5:0]                      o_pos_chan,
  output logic      [5:0]                      o_neg_chan,
  output logic      [2:0]                      o_gain,
  output logic                                 o_end_of_scan,
  output logic                                 o_serial_valid,
  output logic      [aisp_pkg::DATA_W-1:0]     o_serial_data
);

  localparam int DW  = aisp_pkg::DATA_W;
  localparam int RW  = aisp_pkg::RESULT_W;
  localparam int QCW = $clog2(QUEUE_DEPTH + 1);
  localparam int SPW = $clog2(SETUP_DEPTH);
  localparam int SCW = $clog2(SETUP_DEPTH + 1);
  localparam int EXT = DW - RW;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SPW-1:0] step_ptr
  (
    input logic [SPW-1:0] ptr,
    input logic [SCW-1:0] used
  );
    logic [SCW-1:0] nxt;
    nxt = SCW'(ptr) + 1'b1;
    step_ptr = (nxt >= used) ? '0 : SPW'(nxt);
  endfunction

  function automatic logic hit
  (
    input logic [aisp_pkg::ADDR_W-1:0] a,
    input logic [aisp_pkg::ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // pin resynchronisers
  // ----------------------------------------------------------------
  // bit 0 start pin, bit 1 converter busy_n pin; a level counts only
  // once stages two and three agree, which rejects a single glitch
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s3_reg;
  logic [1:0] pin_f_reg;
  logic [1:0] pin_f_next;

  assign pin_f_next = (pin_f_reg & (pin_s2_reg ^ pin_s3_reg))
                    | (pin_s2_reg & (pin_s2_reg ~^ pin_s3_reg));

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pin_s1_reg <= 2'h2;
      pin_s2_reg <= 2'h2;
      pin_s3_reg <= 2'h2;
      pin_f_reg  <= 2'h2;
    end
    else if (i_ce)
    begin
      pin_s1_reg <= {i_adc_busy_n_pin, i_conv_start_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg  <= pin_f_next;
    end
  end

  logic start_edge;
  logic busy_rise;
  logic busy_fall;
  logic idle_lvl;

  assign idle_lvl   = pin_f_reg[1];
  assign start_edge = pin_f_next[0] & ~pin_f_reg[0];
  assign busy_rise  = pin_f_next[1] & ~pin_f_reg[1];
  assign busy_fall  = ~pin_f_next[1] & pin_f_reg[1];

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_setup;
  logic wr_ctrl;
  logic rd_queue;
  logic clr_err;
  logic setup_clr;
  logic setup_load;
  logic list_restart;

  // writes to queue, state and flag words decode to nothing
  assign wr_setup     = i_wr & hit(i_addr, aisp_pkg::OFF_SETUP);
  assign wr_ctrl      = i_wr & hit(i_addr, aisp_pkg::OFF_CTRL);
  assign rd_queue     = i_rd & hit(i_addr, aisp_pkg::OFF_QUEUE);
  assign clr_err      = wr_ctrl & i_wdata[aisp_pkg::CT_CLR_ERR];
  assign setup_clr    = wr_ctrl & i_wdata[aisp_pkg::CT_SETUP_CLR];
  assign setup_load   = wr_ctrl & i_wdata[aisp_pkg::CT_SETUP_LOAD];
  assign list_restart = wr_ctrl & i_wdata[aisp_pkg::CT_RESTART];

  // ----------------------------------------------------------------
  // channel setup memory
  // ----------------------------------------------------------------
  logic [DW-1:0]  setup_mem [SETUP_DEPTH];
  logic [SCW-1:0] setup_used_reg;
  logic [SPW-1:0] setup_ptr_reg;
  logic [DW-1:0]  cur_entry_reg;
  logic           setup_room;
  logic           entry_step;

  assign setup_room = (setup_used_reg < SCW'(SETUP_DEPTH));

  always_ff @(posedge i_clk)
  begin
    if (i_ce && wr_setup && setup_room && !setup_clr)
    begin
      setup_mem[SPW'(setup_used_reg)] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      setup_used_reg <= '0;
      setup_ptr_reg  <= '0;
      cur_entry_reg  <= '0;
    end
    else if (i_ce)
    begin
      if (setup_clr)
      begin
        setup_used_reg <= '0;
        setup_ptr_reg  <= '0;
      end
      else if (wr_setup && setup_room)
      begin
        setup_used_reg <= setup_used_reg + 1'b1;
      end
      if (setup_load || entry_step)
      begin
        cur_entry_reg <= setup_mem[setup_ptr_reg];
        setup_ptr_reg <= step_ptr(setup_ptr_reg, setup_used_reg);
      end
      else if (list_restart)
      begin
        setup_ptr_reg <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // routing of the current entry
  // ----------------------------------------------------------------
  logic [5:0] sel;
  logic       ext_neg;
  logic [5:0] differential_input_pos;
  logic [5:0] differential_input_neg;
  logic [1:0] route_next;

  assign sel     = cur_entry_reg[aisp_pkg::F_SEL_HI:aisp_pkg::F_SEL_LO];
  assign ext_neg = (sel >= aisp_pkg::CH_EXT_NEG);
  assign differential_input_pos = (sel < aisp_pkg::CH_EXT_FIRST)
                  ? {aisp_pkg::CH_POS_BANK, sel[2:0]}
                  : (ext_neg ? sel - aisp_pkg::CH_EXT_SPAN : sel);
  assign differential_input_neg = (sel < aisp_pkg::CH_EXT_FIRST)
                  ? {aisp_pkg::CH_NEG_BANK, sel[2:0]}
                  : (ext_neg ? sel : sel + aisp_pkg::CH_EXT_SPAN);
  assign route_next =
      cur_entry_reg[aisp_pkg::F_CAL] ? aisp_pkg::ROUTE_CAL
    : !cur_entry_reg[aisp_pkg::F_SE] ? aisp_pkg::ROUTE_DIFFERENTIAL_INPUT
    : cur_entry_reg[aisp_pkg::F_AIS] ? aisp_pkg::ROUTE_UNREF
    : aisp_pkg::ROUTE_REF;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_route_mode <= aisp_pkg::ROUTE_CAL;
      o_pos_chan   <= '0;
      o_neg_chan   <= '0;
      o_gain       <= '0;
    end
    else if (i_ce)
    begin
      o_route_mode <= route_next;
      o_pos_chan   <= (route_next == aisp_pkg::ROUTE_DIFFERENTIAL_INPUT) ? differential_input_pos : sel;
      o_neg_chan   <= (route_next == aisp_pkg::ROUTE_DIFFERENTIAL_INPUT) ? differential_input_neg : '0;
      o_gain       <= cur_entry_reg[aisp_pkg::F_GAIN_HI:aisp_pkg::F_GAIN_LO];
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  aisp_pkg::conv_state_e conv_reg;
  logic [DW-1:0]         conv_entry_reg;
  logic [RW-1:0]         adc_data_reg;
  logic                  conv_active;
  logic                  start_ok;
  logic                  conv_done;
  logic                  collision_set;

  // converter counts as active from our own start until busy_n returns
  assign conv_active   = (conv_reg != aisp_pkg::CONV_IDLE) | ~idle_lvl;
  assign start_ok      = start_edge & ~conv_active;
  assign collision_set = start_edge & conv_active;
  assign conv_done     = (conv_reg == aisp_pkg::CONV_RUN) & busy_rise;
  assign entry_step    = start_ok;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      conv_reg       <= aisp_pkg::CONV_IDLE;
      conv_entry_reg <= '0;
      adc_data_reg   <= '0;
      o_adc_start    <= 1'b0;
    end
    else if (i_ce)
    begin
      adc_data_reg <= i_adc_data;
      o_adc_start  <= start_ok;
      case (conv_reg)
        aisp_pkg::CONV_IDLE:
        begin
          if (start_ok)
          begin
            conv_entry_reg <= cur_entry_reg;
            conv_reg       <= aisp_pkg::CONV_ARM;
          end
        end
        aisp_pkg::CONV_ARM:
        begin
          if (busy_fall)
          begin
            conv_reg <= aisp_pkg::CONV_RUN;
          end
        end
        aisp_pkg::CONV_RUN:
        begin
          if (busy_rise)
          begin
            conv_reg <= aisp_pkg::CONV_IDLE;
          end
        end
        default:
        begin
          conv_reg <= aisp_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result formatting and queue
  // ----------------------------------------------------------------
  logic [DW-1:0] result_word;
  logic          conv_bip;

  assign conv_bip    = conv_entry_reg[aisp_pkg::F_BIP];
  assign result_word = {{EXT{conv_bip & adc_data_reg[RW-1]}},
                        adc_data_reg};

  queue_if #(.W(DW), .CW(QCW)) qlink ();

  assign qlink.push      = conv_done & ~conv_entry_reg[aisp_pkg::F_DISCARD];
  assign qlink.push_data = result_word;
  assign qlink.pop       = rd_queue;

  sample_queue
  #(
    .W     (DW),
    .DEPTH (QUEUE_DEPTH),
    .CW    (QCW)
  )
  u_queue
  (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_ce   (i_ce),
    .q      (qlink.store)
  );

  // ----------------------------------------------------------------
  // sticky error flags
  // ----------------------------------------------------------------
  logic overflow_reg;
  logic collision_reg;
  logic overflow_set;

  assign overflow_set = qlink.push & qlink.full;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      overflow_reg  <= 1'b0;
      collision_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      overflow_reg  <= overflow_set | (overflow_reg & ~clr_err);
      collision_reg <= collision_set | (collision_reg & ~clr_err);
    end
  end

  // ----------------------------------------------------------------
  // scan marks and serial forward
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_end_of_scan  <= 1'b0;
      o_serial_valid <= 1'b0;
      o_serial_data  <= '0;
    end
    else if (i_ce)
    begin
      o_end_of_scan  <= conv_done & conv_entry_reg[aisp_pkg::F_LAST];
      o_serial_valid <= conv_done & conv_entry_reg[aisp_pkg::F_SERIAL];
      if (conv_done)
      begin
        o_serial_data <= result_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [aisp_pkg::FL_W-1:0] flags;
  logic [DW-1:0]             rdata_next;
  logic                      below_half;

  assign below_half = (qlink.count < QCW'(QUEUE_DEPTH / 2));
  assign flags = {(setup_used_reg != '0),
                  collision_reg,
                  overflow_reg,
                  below_half,
                  ~qlink.empty};

  // an empty-queue read returns whatever the head slot holds
  assign rdata_next =
      !i_rd                                 ? '0
    : hit(i_addr, aisp_pkg::OFF_QUEUE)      ? qlink.head
    : hit(i_addr, aisp_pkg::OFF_STATE)      ? DW'(idle_lvl)
    : hit(i_addr, aisp_pkg::OFF_FLAGS)      ? DW'(flags)
    : '0;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= '0;
    end
    else if (i_ce)
    begin
      o_rdata <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// file: tb/aisp_properties.sv
// Purpose: port-level properties of the sample port
// Assumes: one clock, i_srst synchronous active high
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module aisp_properties
(
  input wire logic                        i_clk,
  input wire logic                        i_srst,
  input wire logic                        i_ce,
  input wire logic [aisp_pkg::ADDR_W-1:0] i_addr,
  input wire logic                        i_rd,
  input wire logic [aisp_pkg::DATA_W-1:0] o_rdata,
  input wire logic                        i_conv_start_pin,
  input wire logic                        i_adc_busy_n_pin,
  input wire logic                        o_adc_start,
  input wire logic [1:0]                  o_route_mode,
  input wire logic [5:0]                  o_pos_chan,
  input wire logic [5:0]                  o_neg_chan,
  input wire logic                        o_serial_valid
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  logic pair_ok;
  // second range covers selects from 16 up to 39 only
  assign pair_ok = (o_pos_chan < 6'h08 && o_neg_chan == o_pos_chan + 6'h08)
    || (o_pos_chan >= 6'h10 && o_pos_chan < 6'h28
    && o_neg_chan == o_pos_chan + 6'h18);

  sequence busy_held;
    !i_adc_busy_n_pin [*6];
  endsequence

  sequence rd_at(logic [4:0] a);
    i_rd && i_ce && i_addr == a;
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_quiet:
    assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not cleared");
  a_state_upper:
    assert property (rd_at(aisp_pkg::OFF_STATE)
      |=> o_rdata[15:1] == 15'h0000)
    else $error("state word upper bits not zero");
  a_setup_unread:
    assert property (rd_at(aisp_pkg::OFF_SETUP) |=> o_rdata == 16'h0000)
    else $error("setup location read not zero");
  a_busy_reads:
    assert property (busy_held ##0 rd_at(aisp_pkg::OFF_STATE)
      |=> !o_rdata[0])
    else $error("idle bit high while converting");
  a_no_start_busy:
    assert property (busy_held |-> !o_adc_start)
    else $error("start issued while converter busy");
  a_start_cause:
    assert property (o_adc_start |-> $past(i_conv_start_pin, 3))
    else $error("start without a start pin request");
  a_differential_input_pairs:
    assert property (o_route_mode == 2'h0 |-> pair_ok)
    else $error("differential pair out of range");
  a_single_neg:
    assert property (o_route_mode != 2'h0 |-> o_neg_chan == 6'h00)
    else $error("negative channel set outside differential");
  a_serial_pulse:
    assert property (o_serial_valid |=> !o_serial_valid)
    else $error("serial valid longer than one cycle");
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the analog input sample port
// Assumes: default depths, clock enable held high
// Notes:   queue model is a plain word queue; pins driven directly
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // stimulus and model state
  // ----------------------------------------
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        st = 1'b0, bsy = 1'b1, go, eos, sv;
  logic [4:0]  adr = 5'h00;
  logic [15:0] wd = 16'h0000, rdat, sdat, d, e0;
  logic [11:0] ad = 12'h000;
  logic [1:0]  rm;
  logic [5:0]  pc, nc;
  logic [2:0]  gn;
  logic [31:0] rng = 32'h0001625D;
  logic        ov = 1'b0, co = 1'b0;
  int          n_errors = 0, checks = 0, idx = 0, n = 0;
  logic [15:0] ent[$], q[$];

  analog_input_sample_port u_analog_input_sample_port
  (
    .i_clk            (clk),
    .i_srst           (srst),
    .i_ce             (1'b1),
    .i_addr           (adr),
    .i_wdata          (wd),
    .i_wr             (wr),
    .i_rd             (rd),
    .o_rdata          (rdat),
    .i_conv_start_pin (st),
    .i_adc_busy_n_pin (bsy),
    .i_adc_data       (ad),
    .o_adc_start      (go),
    .o_route_mode     (rm),
    .o_pos_chan       (pc),
    .o_neg_chan       (nc),
    .o_gain           (gn),
    .o_end_of_scan    (eos),
    .o_serial_valid   (sv),
    .o_serial_data    (sdat)
  );

  initial
  begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // model and tasks
  // ----------------------------------------
  function automatic void step();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
  endfunction

  function automatic logic [16:0] rexp(input logic [15:0] e);
    logic [5:0] s;
    s = e[11:6];
    if (e[13]) return {2'h3, s, 6'h00, e[5:3]};
    if (e[15]) return {e[14] ? 2'h2 : 2'h1, s, 6'h00, e[5:3]};
    if (s < 6'h10) return {5'h00, s[2:0], 3'h1, s[2:0], e[5:3]};
    if (s < 6'h28) return {2'h0, s, s + 6'h18, e[5:3]};
    return {2'h0, s - 6'h18, s, e[5:3]};
  endfunction

  function automatic logic [15:0] fexp();
    return {11'h000, n > 0, co, ov, q.size() < 256, q.size() > 0};
  endfunction

  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_route(input logic [16:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD route t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bw(input logic [4:0] a, input logic [15:0] v);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // data sampled at the edge closing the answer cycle
  task automatic br(input logic [4:0] a, output logic [15:0] v);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdat;
  endtask

  task automatic chk_flags();
    br(aisp_pkg::OFF_FLAGS, d);
    cmp(d, fexp());
  endtask

  task automatic drain(input int cnt);
    repeat (cnt)
    begin
      br(aisp_pkg::OFF_QUEUE, d);
      cmp(d, q.pop_front());
    end
  endtask

  task automatic load_list();
    bw(aisp_pkg::OFF_CTRL, 16'h0001 << aisp_pkg::CT_SETUP_CLR);
    foreach (ent[i])
      bw(aisp_pkg::OFF_SETUP, ent[i]);
    bw(aisp_pkg::OFF_CTRL, 16'h0001 << aisp_pkg::CT_SETUP_LOAD);
    n = ent.size();
    idx = 0;
  endtask

  // dbl raises the start pin again while the converter is busy
  task automatic conv(input logic dbl);
    logic [15:0] e, x;
    logic [11:0] v;
    logic        s_seen, e_seen;
    int          k;
    e = ent[idx];
    step();
    v = rng[11:0];
    x = e[12] ? {{4{v[11]}}, v} : {4'h0, v};
    @(posedge clk);
    cmp_route({rm, pc, nc, gn}, rexp(e));
    st <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!go && k < 12);
    cmp({15'h0000, go}, 16'h0001);
    st <= 1'b0;
    bsy <= 1'b0;
    ad <= v;
    // low long enough for the pin filter to see a fresh edge
    repeat (3) @(posedge clk);
    st <= dbl;
    repeat (4) @(posedge clk);
    st <= 1'b0;
    br(aisp_pkg::OFF_STATE, d);
    cmp(d, 16'h0000);
    bsy <= 1'b1;
    if (!e[1] && q.size() < 512) q.push_back(x);
    else if (!e[1]) ov = 1'b1;
    co = co | dbl;
    s_seen = 1'b0;
    e_seen = 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      if (sv) cmp(sdat, x);
      s_seen = s_seen | sv;
      e_seen = e_seen | eos;
    end
    cmp({14'h0000, e_seen, s_seen}, {14'h0000, e[2], e[0]});
    idx = (idx + 1) % n;
  endtask

  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    br(aisp_pkg::OFF_STATE, d);
    cmp(d, 16'h0001);
    chk_flags();
    for (int i = 0; i < 8; i++)
    begin
      step();
      e0 = rng[15:0];
      e0[15] = i[0];
      e0[13] = (i == 6);
      e0[1] = (i == 3);
      e0[2] = (i == 7);
      ent.push_back(e0);
    end
    load_list();
    for (int i = 0; i < 10; i++)
      conv(i == 4);
    chk_flags();
    br(aisp_pkg::OFF_SETUP, d);
    cmp(d, 16'h0000);
    br(5'h04, d);
    cmp(d, 16'h0000);
    step();
    bw(aisp_pkg::OFF_QUEUE, rng[15:0]);
    bw(aisp_pkg::OFF_STATE, rng[31:16]);
    bw(aisp_pkg::OFF_FLAGS, rng[15:0]);
    chk_flags();
    bw(aisp_pkg::OFF_CTRL, 16'h0001 << aisp_pkg::CT_CLR_ERR);
    co = 1'b0;
    chk_flags();
    drain(q.size());
    br(aisp_pkg::OFF_QUEUE, d);
    chk_flags();
    ent.delete();
    step();
    e0 = rng[15:0];
    e0[12] = 1'b1;
    e0[0] = 1'b1;
    e0[1] = 1'b0;
    ent.push_back(e0);
    load_list();
    while (q.size() < 255) conv(1'b0);
    chk_flags();
    conv(1'b0);
    chk_flags();
    while (!ov) conv(1'b0);
    chk_flags();
    drain(q.size());
    chk_flags();
    finish_test();
  end

  // bound is about two and a half times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule

bind analog_input_sample_port aisp_properties u_aisp_properties
(
  .i_clk            (i_clk),
  .i_srst           (i_srst),
  .i_ce             (i_ce),
  .i_addr           (i_addr),
  .i_rd             (i_rd),
  .o_rdata          (o_rdata),
  .i_conv_start_pin (i_conv_start_pin),
  .i_adc_busy_n_pin (i_adc_busy_n_pin),
  .o_adc_start      (o_adc_start),
  .o_route_mode     (o_route_mode),
  .o_pos_chan       (o_pos_chan),
  .o_neg_chan       (o_neg_chan),
  .o_serial_valid   (o_serial_valid)
);
`default_nettype wire
